//--- verif/peripheral_input_remap_sva.sv
/*
  checker for the remap block ports.
  assumes one bus master, one clock, strap held steady.
*/
`timescale 1ns/10ps
module remap_sva
  import pin_remap_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic [31:0] HRDATA_O,
  input wire logic [31:0] REMAP_PIN_I,
  input wire logic [3:0] VIRTUAL_PIN_I,
  input wire logic ONE_WAY_LOCK_OPTION_I,
  input wire periph_in_t PERIPH_IN_O,
  input wire logic PIN_SELECT_LOCK_O
);
  // ****
  // helpers
  // ****
  logic take;
  logic osc_dph;
  logic wr_dph;
  logic any_wr;
  logic [15:0] keys;
  logic [35:0] pins_q;
  logic [3:0] quiet;
  assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
    begin
      osc_dph <= 1'b0;
      wr_dph <= 1'b0;
      any_wr <= 1'b0;
      keys <= 16'h0;
    end
    else
    begin
      osc_dph <= take && HWRITE_I && HADDR_I[11:0] == OSC_CTRL_ADDR;
      wr_dph <= take && HWRITE_I;
      any_wr <= any_wr || (take && HWRITE_I);
      if (osc_dph)
        keys <= {keys[7:0], HWDATA_I[7:0]};
      else if (wr_dph)
        keys <= 16'h0;
    end
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
    begin
      pins_q <= '0;
      quiet <= 4'h0;
    end
    else
    begin
      pins_q <= {REMAP_PIN_I, VIRTUAL_PIN_I};
      if (take || pins_q != {REMAP_PIN_I, VIRTUAL_PIN_I})
        quiet <= 4'h0;
      else if (quiet != 4'hf)
        quiet <= quiet + 4'h1;
    end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  a_okay_resp: assert property (take |=> HREADYOUT_O && !HRESP_O)
    else $error("bus answer not ready okay");
  a_rdata_pad: assert property ((HRDATA_O & 32'hffffc080) == 32'h0)
    else $error("unimplemented read bits set");
  a_rdata_hold: assert property (!$stable(HRDATA_O) |-> $past(take && !HWRITE_I))
    else $error("read data moved without a read");
  a_lock_cause: assert property (!$stable(PIN_SELECT_LOCK_O) |->
    $past(osc_dph) && PIN_SELECT_LOCK_O == $past(HWDATA_I[6]))
    else $error("lock moved without an osc write");
  a_lock_keys: assert property (!$stable(PIN_SELECT_LOCK_O) |-> $past(keys) == 16'h4657)
    else $error("lock moved without both keys");
  a_one_way_hold: assert property (PIN_SELECT_LOCK_O && ONE_WAY_LOCK_OPTION_I &&
    $past(ONE_WAY_LOCK_OPTION_I, 3) |=> PIN_SELECT_LOCK_O)
    else $error("one-way lock cleared");
  a_reset_low: assert property (!any_wr |-> PERIPH_IN_O == '0)
    else $error("input not tied low after reset");
  a_route_quiet: assert property (quiet >= 4'h3 |-> $stable(PERIPH_IN_O))
    else $error("routing moved with no cause");
  cover property ($rose(PIN_SELECT_LOCK_O));
  cover property (take && HWRITE_I && PIN_SELECT_LOCK_O);
  cover property (quiet == 4'h3 && PERIPH_IN_O != '0);
endmodule
bind peripheral_input_remap remap_sva chk_u (.CORE_CLK_I, .ARST_N_I, .HSEL_I, .HADDR_I, .HTRANS_I,
  .HWRITE_I, .HWDATA_I, .HREADY_I, .HREADYOUT_O, .HRESP_O, .HRDATA_O, .REMAP_PIN_I, .VIRTUAL_PIN_I,
  .ONE_WAY_LOCK_OPTION_I, .PERIPH_IN_O, .PIN_SELECT_LOCK_O);

//--- verif/pin_source_model.sv
/*
  pin source: drives the remappable and virtual pins seen by the remap block.
  assumes the bench sets the levels; pins move just after a clock edge.
*/
`timescale 1ns/10ps
module pin_source_model
(
  input wire logic clk_i,
  input wire logic [31:0] pin_level_i,
  input wire logic [3:0] virt_level_i,
  output logic [31:0] pin_o = '0,
  output logic [3:0] virt_o = '0
);
  always @(posedge clk_i)
  begin
    pin_o <= pin_level_i;
    virt_o <= virt_level_i;
  end
endmodule

//--- verif/tb_top.sv
/*
  bench for the remap block: ahb-lite master tasks, routing, lock and reset tests.
  assumes the pin source model and the bound checker.
*/
`timescale 1ns/10ps
module tb_top
  import pin_remap_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic strap = 1'b0;
  logic [31:0] pin_pat = '0;
  logic [3:0] virt_pat = '0;
  logic [31:0] remap_pin;
  logic [3:0] virt_pin;
  logic hready;
  logic [31:0] hrdata;
  periph_in_t periph;
  logic lock;
  logic [5:0] cd [15];
  int ridx [10] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10};
  bit hi_on [10] = '{1, 0, 1, 1, 0, 1, 1, 0, 1, 1};
  bit lo_on [10] = '{0, 1, 1, 1, 1, 1, 1, 1, 0, 1};
  int fail_count = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  pin_source_model part_u (.clk_i(clk), .pin_level_i(pin_pat), .virt_level_i(virt_pat),
    .pin_o(remap_pin), .virt_o(virt_pin));
  peripheral_input_remap dut_u (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(), .HRDATA_O(hrdata),
    .REMAP_PIN_I(remap_pin), .VIRTUAL_PIN_I(virt_pin), .ONE_WAY_LOCK_OPTION_I(strap),
    .PERIPH_IN_O(periph), .PIN_SELECT_LOCK_O(lock));
  // ****
  // tasks
  // ****
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(hrdata, e);
  endtask
  task automatic seq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic e);
    xfer(1'b1, OSC_CTRL_ADDR, {24'h0, a});
    xfer(1'b1, OSC_CTRL_ADDR, {24'h0, b});
    xfer(1'b1, OSC_CTRL_ADDR, {24'h0, c});
    @(posedge clk);
    chk({31'h0, lock}, {31'h0, e});
    rd(OSC_CTRL_ADDR, {25'h0, e, 6'h0});
  endtask
  task automatic set_codes();
    logic [31:0] w;
    logic [31:0] m;
    int p;
    p = 0;
    for (int r = 0; r < 10; r++)
    begin
      w = 32'hffffffff;
      m = 32'h0;
      if (lo_on[r])
      begin
        w[5:0] = cd[p];
        m[5:0] = 6'h3f;
        p++;
      end
      if (hi_on[r])
      begin
        w[13:8] = cd[p];
        m[13:8] = 6'h3f;
        p++;
      end
      xfer(1'b1, IN_SEL_BASE + 12'(4 * ridx[r]), w);
      rd(IN_SEL_BASE + 12'(4 * ridx[r]), w & m);
    end
  endtask
  task automatic route(input logic [31:0] pp, input logic [3:0] vp);
    logic [14:0] e;
    pin_pat <= pp;
    virt_pat <= vp;
    repeat (6) @(posedge clk);
    for (int p = 0; p < 15; p++)
      e[p] = cd[p] < 6'h20 ? pp[cd[p][4:0]] : (cd[p] < 6'h24 ? vp[cd[p][1:0]] : 1'b0);
    chk({17'h0, periph}, {17'h0, e});
  endtask
  task automatic reset_chk();
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({17'h0, periph}, 32'h0);
    chk({31'h0, lock}, 32'h0);
    for (int r = 0; r < 10; r++)
      rd(IN_SEL_BASE + 12'(4 * ridx[r]), {18'h0, hi_on[r] ? 6'h3f : 6'h0, 2'h0, lo_on[r] ? 6'h3f : 6'h0});
    rd(OUT_SEL_BASE, 32'h0);
  endtask
  initial
  begin
    reset_chk();
    for (int k = 0; k < 4; k++)
    begin
      for (int p = 0; p < 15; p++)
        cd[p] = k == 0 ? 6'(p) : k == 1 ? 6'(31 - p) : k == 2 ? 6'(32 + p % 4) : (p == 14 ? 6'h3f : 6'(36 + p));
      set_codes();
      route(32'h6b2d4c93, 4'h6);
      route(32'h94d2b36c, 4'h9);
    end
    rd(12'h03c, 32'h0);
    xfer(1'b1, 12'h084, 32'hffffffff);
    rd(12'h084, 32'h0);
    xfer(1'b1, OUT_SEL_BASE + 12'h040, 32'hffffffff);
    rd(OUT_SEL_BASE + 12'h040, 32'h00003f3f);
    seq(8'h46, 8'h12, 8'h40, 1'b0);
    xfer(1'b1, OSC_CTRL_ADDR, 32'h46);
    xfer(1'b1, OSC_CTRL_ADDR, 32'h57);
    xfer(1'b1, 12'h084, 32'h0);
    seq(8'h40, 8'h40, 8'h40, 1'b0);
    seq(8'h46, 8'h57, 8'h40, 1'b1);
    xfer(1'b1, IN_SEL_BASE, 32'h0);
    rd(IN_SEL_BASE, {18'h0, cd[0], 8'h0});
    seq(8'h46, 8'h57, 8'h00, 1'b0);
    strap <= 1'b1;
    seq(8'h46, 8'h57, 8'h40, 1'b1);
    seq(8'h46, 8'h57, 8'h00, 1'b1);
    reset_chk();
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule

//--- verilog/peripheral_input_remap.sv
/*
  peripheral input remap: selector registers on ahb-lite routing remappable pins,
  virtual pins or ground to peripheral inputs, guarded by a keyed lock bit.
  assumes pins are asynchronous, virtual pins come from logic on CORE_CLK_I,
  and a single bus master issuing single word transfers.
*/
// The address map and the AHB-Lite interface to the registers were left to the implementer.
// Notes on behaviour
// RULE1: selector writes take effect only while unlocked
// RULE2: fifteen input, seventeen output selector registers
// RULE3: absent output registers removed by parameter
// RULE4: ext int1 selector bits 13-8 only
// RULE5: ext int2 selector bits 5-0 only
// RULE6: timer3 clock high, timer2 clock low
// RULE7: capture2 high field, capture1 low field
// RULE8: compare fault selector bits 5-0 only
// RULE9: uart cts high field, rx low
// RULE10: spi clock high field, data low
// RULE11: spi slave select bits 5-0 only
// RULE12: pwm fault1 selector bits 13-8 only
// RULE13: pwm fault3 high field, fault2 low
// RULE14: all-ones code ties input low
// RULE15: codes 0x20-0x23 pick virtual pins
// RULE16: code zero picks remappable pin zero
// RULE17: input fields reset to all ones
// RULE18: unimplemented bits ignore writes, read zero
// RULE19: code n routes remappable pin n
// RULE20: software unlocks with 0x46, 0x57, write
// RULE21: locked writes complete okay, lock bit six
// RULE22: one-way option holds lock until reset
// RULE23: codes naming no pin tie low
// RULE24: plain mux from stored field, no pipeline; the code registers the mux output into PERIPH_IN_O, one clock later
`timescale 1ns/10ps
module peripheral_input_remap
  import pin_remap_pkg::*;
#(
  parameter logic [NUM_OUT_REGS-1:0] OUT_REG_PRESENT = 17'h1ffff
)
(
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  input wire logic [NUM_PHYS_PINS-1:0] REMAP_PIN_I,
  input wire logic [NUM_VIRT_PINS-1:0] VIRTUAL_PIN_I,
  input wire logic ONE_WAY_LOCK_OPTION_I,
  output periph_in_t PERIPH_IN_O,
  output logic PIN_SELECT_LOCK_O
);

  // ****************************************
  // declarations
  // ****************************************
  logic [NUM_PHYS_PINS-1:0] pin_meta;
  logic [NUM_PHYS_PINS-1:0] pin_sync;
  logic one_way_meta;
  logic one_way_sync;
  bus_req_t data_phase;
  bus_req_t next_data_phase;
  logic [5:0] in_hi [NUM_IN_REGS];
  logic [5:0] in_lo [NUM_IN_REGS];
  logic [5:0] next_in_hi [NUM_IN_REGS];
  logic [5:0] next_in_lo [NUM_IN_REGS];
  logic [5:0] out_hi [NUM_OUT_REGS];
  logic [5:0] out_lo [NUM_OUT_REGS];
  logic [5:0] next_out_hi [NUM_OUT_REGS];
  logic [5:0] next_out_lo [NUM_OUT_REGS];
  logic pin_select_lock;
  logic next_lock;
  unlock_state_t unlock_state;
  unlock_state_t next_unlock_state;
  logic osc_wr;
  logic sel_wr;
  logic [31:0] next_rdata;
  logic [NUM_PHYS_PINS+NUM_VIRT_PINS-1:0] source_pool;
  logic [NUM_PERIPH-1:0] next_periph;
  logic [NUM_IN_REGS-1:0] wr_in_hit;
  logic [NUM_IN_REGS-1:0] rd_in_hit;
  logic [NUM_OUT_REGS-1:0] wr_out_hit;
  logic [NUM_OUT_REGS-1:0] rd_out_hit;
  logic sel_wr_open;
  logic key1_match;
  logic key2_match;
  logic lock_frozen;
  logic rd_take;

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      one_way_meta <= 1'b0;
      one_way_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= REMAP_PIN_I;
      pin_sync <= pin_meta;
      one_way_meta <= ONE_WAY_LOCK_OPTION_I;
      one_way_sync <= one_way_meta;
    end
  end

  // ****************************************
  // ahb-lite address phase capture
  // ****************************************
  always_comb
  begin
    next_data_phase.addr = HADDR_I[11:0];
    next_data_phase.write = HWRITE_I;
    next_data_phase.valid = HSEL_I && HTRANS_I[1] && HREADY_I;
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      data_phase <= '0;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
    else
    begin
      if (HREADY_I)
      begin
        data_phase <= next_data_phase;
      end
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  assign sel_wr = data_phase.valid && data_phase.write && (data_phase.addr != OSC_CTRL_ADDR);
  assign osc_wr = data_phase.valid && data_phase.write && (data_phase.addr == OSC_CTRL_ADDR);
  assign sel_wr_open = sel_wr && !pin_select_lock; // [RULE1] [RULE21]
  assign rd_take = next_data_phase.valid && !HWRITE_I;

  // ****************************************
  // per-register address decode, writes from the data phase, reads from the address phase
  // ****************************************
  generate
    for (genvar i = 0; i < NUM_IN_REGS; i++)
    begin : g_in_dec
      assign wr_in_hit[i] = (data_phase.addr == 12'(IN_SEL_BASE + 4 * i));
      assign rd_in_hit[i] = (HADDR_I[11:0] == 12'(IN_SEL_BASE + 4 * i));
    end
    for (genvar j = 0; j < NUM_OUT_REGS; j++)
    begin : g_out_dec
      assign wr_out_hit[j] = OUT_REG_PRESENT[j] && (data_phase.addr == 12'(OUT_SEL_BASE + 4 * j)); // [RULE3]
      assign rd_out_hit[j] = OUT_REG_PRESENT[j] && (HADDR_I[11:0] == 12'(OUT_SEL_BASE + 4 * j)); // [RULE3]
    end
  endgenerate

  // ****************************************
  // key byte decode
  // ****************************************
  assign key1_match = (HWDATA_I[7:0] == UNLOCK_KEY1);
  assign key2_match = (HWDATA_I[7:0] == UNLOCK_KEY2);
  assign lock_frozen = one_way_sync && pin_select_lock; // [RULE22]

  // ****************************************
  // selector register next values
  // ****************************************
  always_comb
  begin
    next_in_hi = in_hi;
    next_in_lo = in_lo;
    next_out_hi = out_hi;
    next_out_lo = out_lo;
    if (sel_wr_open) // [RULE1] [RULE21]
    begin
      for (int i = 0; i < NUM_IN_REGS; i++)
      begin
        if (wr_in_hit[i])
        begin
          if (IN_HI_IMPL[i]) // [RULE4] [RULE6] [RULE7] [RULE9] [RULE10] [RULE12] [RULE13] [RULE18]
          begin
            next_in_hi[i] = HWDATA_I[HI_MSB:HI_LSB];
          end
          if (IN_LO_IMPL[i]) // [RULE5] [RULE8] [RULE11] [RULE18]
          begin
            next_in_lo[i] = HWDATA_I[LO_MSB:LO_LSB];
          end
        end
      end
      for (int j = 0; j < NUM_OUT_REGS; j++)
      begin
        if (wr_out_hit[j])
        begin
          next_out_hi[j] = HWDATA_I[HI_MSB:HI_LSB];
          next_out_lo[j] = HWDATA_I[LO_MSB:LO_LSB];
        end
      end
    end
  end

  // ****************************************
  // selector register storage
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      for (int i = 0; i < NUM_IN_REGS; i++)
      begin
        in_hi[i] <= IN_FIELD_RESET; // [RULE17]
        in_lo[i] <= IN_FIELD_RESET; // [RULE17]
      end
      for (int j = 0; j < NUM_OUT_REGS; j++) // [RULE2]
      begin
        out_hi[j] <= OUT_FIELD_RESET;
        out_lo[j] <= OUT_FIELD_RESET;
      end
    end
    else
    begin
      in_hi <= next_in_hi;
      in_lo <= next_in_lo;
      out_hi <= next_out_hi;
      out_lo <= next_out_lo;
    end
  end

  // ****************************************
  // lock key sequence
  // ****************************************
  always_comb
  begin
    next_unlock_state = unlock_state;
    next_lock = pin_select_lock;
    if (sel_wr)
    begin
      next_unlock_state = UNLOCK_IDLE;
    end
    else if (osc_wr) // [RULE20]
    begin
      case (unlock_state)
        UNLOCK_IDLE:
        begin
          if (key1_match)
          begin
            next_unlock_state = UNLOCK_KEYED;
          end
        end
        UNLOCK_KEYED:
        begin
          if (key2_match)
          begin
            next_unlock_state = UNLOCK_ARMED;
          end
          else if (key1_match)
          begin
            next_unlock_state = UNLOCK_KEYED;
          end
          else
          begin
            next_unlock_state = UNLOCK_IDLE;
          end
        end
        UNLOCK_ARMED:
        begin
          next_unlock_state = UNLOCK_IDLE;
          if (!lock_frozen) // [RULE22]
          begin
            next_lock = HWDATA_I[LOCK_BIT]; // [RULE21]
          end
        end
        default:
        begin
          next_unlock_state = UNLOCK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      unlock_state <= UNLOCK_IDLE;
      pin_select_lock <= 1'b0;
      PIN_SELECT_LOCK_O <= 1'b0;
    end
    else
    begin
      unlock_state <= next_unlock_state;
      pin_select_lock <= next_lock;
      PIN_SELECT_LOCK_O <= next_lock;
    end
  end

  // ****************************************
  // read data, taken from next values so a write in flight is seen
  // ****************************************
  always_comb
  begin
    next_rdata = '0;
    for (int i = 0; i < NUM_IN_REGS; i++)
    begin
      if (rd_in_hit[i])
      begin
        if (IN_HI_IMPL[i]) // [RULE18]
        begin
          next_rdata[HI_MSB:HI_LSB] = next_in_hi[i];
        end
        if (IN_LO_IMPL[i]) // [RULE18]
        begin
          next_rdata[LO_MSB:LO_LSB] = next_in_lo[i];
        end
      end
    end
    for (int j = 0; j < NUM_OUT_REGS; j++)
    begin
      if (rd_out_hit[j])
      begin
        next_rdata[HI_MSB:HI_LSB] = next_out_hi[j];
        next_rdata[LO_MSB:LO_LSB] = next_out_lo[j];
      end
    end
    if (HADDR_I[11:0] == OSC_CTRL_ADDR)
    begin
      next_rdata[LOCK_BIT] = next_lock;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      HRDATA_O <= '0;
    end
    else if (rd_take)
    begin
      HRDATA_O <= next_rdata;
    end
  end

  // ****************************************
  // input routing multiplexers
  // ****************************************
  assign source_pool = {VIRTUAL_PIN_I, pin_sync};

  generate
    for (genvar p = 0; p < NUM_PERIPH; p++)
    begin : g_route
      logic [5:0] sel;
      assign sel = PERIPH_HI[p] ? in_hi[PERIPH_REG[p]] : in_lo[PERIPH_REG[p]]; // [RULE24]
      // code n picks pin n, 0x20..0x23 the virtual pins, anything else ties low
      assign next_periph[p] = (sel <= SEL_LAST_PIN) ? source_pool[sel] : 1'b0; // [RULE14] [RULE15] [RULE16] [RULE19] [RULE23]
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PERIPH_IN_O <= '0;
    end
    else
    begin
      PERIPH_IN_O <= periph_in_t'(next_periph);
    end
  end

endmodule

//--- verilog/pin_remap_pkg.sv
/*
  constants, register map and carrier types for the peripheral input remap block.
  assumes a 32-bit ahb-lite register bus and a 200 MHz core clock.
*/
package pin_remap_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_IN_REGS = 15;
  localparam int NUM_OUT_REGS = 17;
  localparam int NUM_PERIPH = 15;
  localparam int NUM_PHYS_PINS = 32;
  localparam int NUM_VIRT_PINS = 4;
  localparam int FIELD_W = 6;

  // ****************************************
  // register map (byte addresses, low 12 bits decoded)
  // ****************************************
  localparam logic [11:0] IN_SEL_BASE = 12'h000;
  localparam logic [11:0] OUT_SEL_BASE = 12'h040;
  localparam logic [11:0] OSC_CTRL_ADDR = 12'h100;

  // ****************************************
  // field layout
  // ****************************************
  localparam int HI_LSB = 8;
  localparam int HI_MSB = 13;
  localparam int LO_LSB = 0;
  localparam int LO_MSB = 5;
  localparam int LOCK_BIT = 6;

  // implemented upper / lower field per input select register, bit i = register index i
  localparam logic [NUM_IN_REGS-1:0] IN_HI_IMPL = 15'h3ed9;
  localparam logic [NUM_IN_REGS-1:0] IN_LO_IMPL = 15'h7dfe;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [5:0] IN_FIELD_RESET = 6'h3f;
  localparam logic [5:0] OUT_FIELD_RESET = 6'h00;
  localparam logic [5:0] SEL_TIE_LOW = 6'h3f;
  localparam logic [5:0] SEL_VIRT_FIRST = 6'h20;
  localparam logic [5:0] SEL_LAST_PIN = 6'h23;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h57;

  // ****************************************
  // peripheral to register / lane table, entry p drives peripheral bit p
  // ****************************************
  localparam logic [3:0] PERIPH_REG [NUM_PERIPH] = '{
    4'h0, 4'h1, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h6,
    4'h6, 4'h7, 4'h7, 4'h8, 4'h9, 4'ha, 4'ha};
  localparam logic PERIPH_HI [NUM_PERIPH] = '{
    1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
    1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    UNLOCK_IDLE = 2'b00,
    UNLOCK_KEYED = 2'b01,
    UNLOCK_ARMED = 2'b10
  } unlock_state_t;

  typedef struct packed {
    logic pwm_fault3;
    logic pwm_fault2;
    logic pwm_fault1;
    logic spi_slave_select;
    logic spi_clock_in;
    logic spi_data_in;
    logic uart_cts;
    logic uart_rx;
    logic compare_fault_a;
    logic capture2;
    logic capture1;
    logic timer3_clock;
    logic timer2_clock;
    logic ext_int2;
    logic ext_int1;
  } periph_in_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic valid;
  } bus_req_t;

endpackage
